// ---- hdl/clock_monitor_and_reset_gen.sv ----
// clock manager, frequency monitor and reset generator
`timescale 1ns/1ps
`default_nettype none
module clock_monitor_and_reset_gen #(
  parameter logic [8:0] LOCK_FILTER = clock_monitor_pkg::LOCK_FILTER_TICKS
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // reset sources
  input wire logic ext_reset_n,
  input wire logic power_on_reset_n,
  // reference and multiplier status
  input wire logic backup_tick,
  input wire logic synth_tick,
  input wire logic synth_lock_raw,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [9:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  // serial link status
  input wire logic spi_cs_n,
  input wire logic spi_start,
  output logic spi_abort,
  // multiplier control
  output logic ref_select_backup,
  output logic synth_factor_24,
  output logic spread_enable,
  output logic sys_clk_enable,
  // status and interrupts
  output logic backup_ref_in_use,
  output logic clk_absent,
  output logic core_irq,
  output logic host_interrupt_n,
  output logic drivers_disable,
  // generated resets
  output logic clk_mon_reset,
  output logic cipher_reset,
  output logic spi_reset,
  output logic main_reset
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    clock_monitor_pkg::mgr_state_t st;
    logic [8:0] wait_cnt;
    logic [8:0] lock_cnt;
    logic lock_filt;
    logic valid_prev;
    logic saw_fall;
    logic always_valid;
    logic [15:0] config_reg;
    logic drv_off;
    logic spi_err;
    logic [15:0] code_1;
    logic [3:0] global_cnt;
    logic [15:0] rdata;
    logic abort;
    logic sel_backup;
    logic in_use;
    logic absent;
    logic irq;
    logic irq_n;
    logic drv_dis;
    logic mon_rst;
    logic ciph_rst;
    logic spi_rst;
    logic main_rst;
    logic clk_en;
    logic spread_en;
  } state_t;
  state_t cur, next_cur;

  localparam logic [8:0] SWITCH_TICKS_LESS_RELOCK =
    clock_monitor_pkg::SWITCH_TICKS - clock_monitor_pkg::RELOCK_TICKS;

  logic window_done;
  logic window_bad;
  logic factor_24;

  freq_window u_window (
    .clk_sys(clk_sys),
    .reset(cur.mon_rst),
    .backup_tick(backup_tick),
    .synth_tick(synth_tick),
    .factor_24_req(cur.config_reg[clock_monitor_pkg::BIT_FACTOR_24]),
    .window_done(window_done),
    .window_bad(window_bad),
    .factor_24(factor_24)
  );

  function automatic logic hit(input logic [9:0] a, input logic [9:0] b);
    hit = (a == b);
  endfunction : hit

  // ----------------------------------------
  // next state
  // ----------------------------------------
  logic pin_or_por;
  logic global_rst;
  logic out_valid;
  logic bad_now;

  always_comb begin
    next_cur = cur;
    pin_or_por = !ext_reset_n || !power_on_reset_n;
    global_rst = (cur.global_cnt != 4'h0);
    bad_now = window_done && window_bad;
    out_valid = cur.lock_filt && !window_bad;

    // lock filter over backup periods
    if (!synth_lock_raw) begin
      next_cur.lock_cnt = 9'h000;
      next_cur.lock_filt = 1'b0;
    end else if (backup_tick) begin
      if (cur.lock_cnt >= LOCK_FILTER - 9'h001) begin
        next_cur.lock_filt = 1'b1;
      end else begin
        next_cur.lock_cnt = cur.lock_cnt + 9'h001;
      end
    end
    next_cur.valid_prev = out_valid;

    if (backup_tick && cur.wait_cnt != 9'h000) begin
      next_cur.wait_cnt = cur.wait_cnt - 9'h001;
    end

    // clock manager
    unique case (cur.st)
      clock_monitor_pkg::ST_DISABLED: begin
        if (cur.wait_cnt == 9'h000) begin
          next_cur.st = clock_monitor_pkg::ST_FILTER;
        end
      end
      clock_monitor_pkg::ST_FILTER: begin
        if (cur.lock_filt) begin
          next_cur.st = clock_monitor_pkg::ST_EXTERNAL;
        end
      end
      clock_monitor_pkg::ST_EXTERNAL: begin
        if (bad_now || !cur.lock_filt) begin
          next_cur.st = clock_monitor_pkg::ST_LOCK_BACKUP;
        end
      end
      clock_monitor_pkg::ST_LOCK_BACKUP: begin
        if (cur.lock_filt) begin
          next_cur.st = clock_monitor_pkg::ST_BACKUP;
        end
      end
      clock_monitor_pkg::ST_BACKUP: begin
        if (reg_wr && hit(reg_addr, clock_monitor_pkg::ADDR_BACKUP_STATUS)
            && reg_wdata[clock_monitor_pkg::BIT_SWITCH_BACK]) begin
          next_cur.st = clock_monitor_pkg::ST_SWITCH;
          next_cur.wait_cnt = clock_monitor_pkg::SWITCH_TICKS;
          next_cur.saw_fall = 1'b0;
          next_cur.always_valid = 1'b1;
        end
      end
      clock_monitor_pkg::ST_SWITCH: begin
        if (!out_valid) begin
          next_cur.always_valid = 1'b0;
        end
        if (cur.valid_prev && !out_valid) begin
          next_cur.saw_fall = 1'b1;
        end
        if (cur.saw_fall && !cur.valid_prev && out_valid) begin
          next_cur.st = clock_monitor_pkg::ST_EXTERNAL;
        end else if (cur.always_valid && out_valid
                     && cur.wait_cnt <= SWITCH_TICKS_LESS_RELOCK) begin
          next_cur.st = clock_monitor_pkg::ST_EXTERNAL;
        end else if (cur.wait_cnt == 9'h000 && !out_valid) begin
          next_cur.st = clock_monitor_pkg::ST_LOCK_BACKUP;
        end
      end
    endcase

    // outputs of the manager
    next_cur.sel_backup = (next_cur.st == clock_monitor_pkg::ST_LOCK_BACKUP)
                          || (next_cur.st == clock_monitor_pkg::ST_BACKUP);
    next_cur.in_use = next_cur.sel_backup;
    next_cur.absent = (next_cur.st == clock_monitor_pkg::ST_LOCK_BACKUP)
                      || (next_cur.st == clock_monitor_pkg::ST_SWITCH);
    next_cur.clk_en = next_cur.lock_filt;
    next_cur.irq = next_cur.absent;
    next_cur.irq_n = !next_cur.absent;
    next_cur.drv_dis = next_cur.absent && cur.drv_off;

    // registers
    next_cur.rdata = 16'h0000;
    if (reg_wr) begin
      if (hit(reg_addr, clock_monitor_pkg::ADDR_SYNTH_CONFIG)) begin
        next_cur.config_reg = {14'h0000, reg_wdata[1:0]};
      end
      if (hit(reg_addr, clock_monitor_pkg::ADDR_BACKUP_STATUS)) begin
        next_cur.drv_off = reg_wdata[clock_monitor_pkg::BIT_DRV_OFF];
      end
      if (hit(reg_addr, clock_monitor_pkg::ADDR_GLOBAL_RESET_1)) begin
        next_cur.code_1 = reg_wdata;
      end
      if (hit(reg_addr, clock_monitor_pkg::ADDR_GLOBAL_RESET_2)
          && reg_wdata == clock_monitor_pkg::GLOBAL_CODE_2
          && cur.code_1 == clock_monitor_pkg::GLOBAL_CODE_1) begin
        next_cur.global_cnt = clock_monitor_pkg::GLOBAL_RESET_CYCLES;
      end
    end
    next_cur.spread_en = !next_cur.config_reg[clock_monitor_pkg::BIT_SPREAD_OFF];
    if (reg_rd) begin
      if (hit(reg_addr, clock_monitor_pkg::ADDR_SYNTH_CONFIG)) begin
        next_cur.rdata = cur.config_reg;
      end
      if (hit(reg_addr, clock_monitor_pkg::ADDR_BACKUP_STATUS)) begin
        next_cur.rdata = {14'h0000, cur.drv_off, cur.in_use};
      end
      if (hit(reg_addr, clock_monitor_pkg::ADDR_SPI_ERROR)) begin
        next_cur.rdata = {15'h0000, cur.spi_err};
        next_cur.spi_err = 1'b0;
      end
    end
    if (global_rst) begin
      next_cur.global_cnt = cur.global_cnt - 4'h1;
      if (cur.global_cnt == 4'h1) begin
        next_cur.code_1 = 16'h0000;
      end
    end

    // serial transfer during clock-absent
    next_cur.abort = spi_start && cur.absent;
    if (spi_start && cur.absent) begin
      next_cur.spi_err = 1'b1;
    end

    // reset generation
    if (pin_or_por) begin
      next_cur.mon_rst = 1'b1;
    end else if (backup_tick) begin
      next_cur.mon_rst = 1'b0;
    end
    next_cur.ciph_rst = !power_on_reset_n;
    if (pin_or_por || global_rst || cur.absent) begin
      next_cur.spi_rst = 1'b1;
    end else if (spi_cs_n) begin
      next_cur.spi_rst = 1'b0;
    end
    next_cur.main_rst = pin_or_por || global_rst;
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset || cur.mon_rst) begin
      cur.st <= clock_monitor_pkg::ST_DISABLED;
      cur.wait_cnt <= clock_monitor_pkg::STARTUP_TICKS;
      cur.lock_cnt <= 9'h000;
      cur.lock_filt <= 1'b0;
      cur.valid_prev <= 1'b0;
      cur.saw_fall <= 1'b0;
      cur.always_valid <= 1'b0;
      cur.sel_backup <= 1'b0;
      cur.in_use <= 1'b0;
      cur.absent <= 1'b0;
      cur.irq <= 1'b0;
      cur.irq_n <= 1'b1;
      cur.drv_dis <= 1'b0;
      cur.clk_en <= 1'b0;
    end else begin
      cur.st <= next_cur.st;
      cur.wait_cnt <= next_cur.wait_cnt;
      cur.lock_cnt <= next_cur.lock_cnt;
      cur.lock_filt <= next_cur.lock_filt;
      cur.valid_prev <= next_cur.valid_prev;
      cur.saw_fall <= next_cur.saw_fall;
      cur.always_valid <= next_cur.always_valid;
      cur.sel_backup <= next_cur.sel_backup;
      cur.in_use <= next_cur.in_use;
      cur.absent <= next_cur.absent;
      cur.irq <= next_cur.irq;
      cur.irq_n <= next_cur.irq_n;
      cur.drv_dis <= next_cur.drv_dis;
      cur.clk_en <= next_cur.clk_en;
    end
    if (reset) begin
      cur.mon_rst <= 1'b1;
      cur.ciph_rst <= 1'b1;
      cur.spi_rst <= 1'b1;
      cur.main_rst <= 1'b1;
      cur.global_cnt <= 4'h0;
      cur.code_1 <= 16'h0000;
    end else begin
      cur.mon_rst <= next_cur.mon_rst;
      cur.ciph_rst <= next_cur.ciph_rst;
      cur.spi_rst <= next_cur.spi_rst;
      cur.main_rst <= next_cur.main_rst;
      cur.global_cnt <= next_cur.global_cnt;
      cur.code_1 <= next_cur.code_1;
    end
    if (reset || cur.main_rst) begin
      cur.config_reg <= clock_monitor_pkg::SYNTH_CONFIG_RESET;
      cur.drv_off <= 1'b0;
      cur.spi_err <= 1'b0;
      cur.rdata <= 16'h0000;
      cur.abort <= 1'b0;
      cur.spread_en <= !clock_monitor_pkg::SYNTH_CONFIG_RESET[clock_monitor_pkg::BIT_SPREAD_OFF];
    end else begin
      cur.config_reg <= next_cur.config_reg;
      cur.drv_off <= next_cur.drv_off;
      cur.spi_err <= next_cur.spi_err;
      cur.rdata <= next_cur.rdata;
      cur.abort <= next_cur.abort;
      cur.spread_en <= next_cur.spread_en;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign reg_rdata = cur.rdata;
  assign spi_abort = cur.abort;
  assign ref_select_backup = cur.sel_backup;
  assign synth_factor_24 = factor_24;
  assign spread_enable = cur.spread_en;
  assign sys_clk_enable = cur.clk_en;
  assign backup_ref_in_use = cur.in_use;
  assign clk_absent = cur.absent;
  assign core_irq = cur.irq;
  assign host_interrupt_n = cur.irq_n;
  assign drivers_disable = cur.drv_dis;
  assign clk_mon_reset = cur.mon_rst;
  assign cipher_reset = cur.ciph_rst;
  assign spi_reset = cur.spi_rst;
  assign main_reset = cur.main_rst;
endmodule : clock_monitor_and_reset_gen
`default_nettype wire

// ---- hdl/clock_monitor_pkg.sv ----
// constants for the clock monitor and reset generator
package clock_monitor_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [9:0] ADDR_SYNTH_CONFIG = 10'h1c6;
  localparam logic [9:0] ADDR_BACKUP_STATUS = 10'h1c7;
  localparam logic [9:0] ADDR_GLOBAL_RESET_1 = 10'h1d0;
  localparam logic [9:0] ADDR_GLOBAL_RESET_2 = 10'h1d1;
  localparam logic [9:0] ADDR_SPI_ERROR = 10'h1d3;
  localparam logic [15:0] SYNTH_CONFIG_RESET = 16'h0001;
  localparam int BIT_FACTOR_24 = 0;
  localparam int BIT_SPREAD_OFF = 1;
  localparam int BIT_IN_USE = 0;
  localparam int BIT_DRV_OFF = 1;
  localparam int BIT_SWITCH_BACK = 2;
  localparam int BIT_SPI_ERR = 0;
  localparam logic [15:0] GLOBAL_CODE_1 = 16'hf473;
  localparam logic [15:0] GLOBAL_CODE_2 = 16'h57a1;
  localparam logic [3:0] GLOBAL_RESET_CYCLES = 4'h8;
  // ----------------------------------------
  // timing, counted in backup reference periods
  // ----------------------------------------
  localparam int BACKUP_PERIOD_NS = 1000;
  localparam int STARTUP_WAIT_US = 100;
  localparam int SWITCH_MUTE_US = 250;
  localparam int RELOCK_WAIT_US = 100;
  localparam int LOCK_FILTER_US = 16;
  localparam logic [8:0] STARTUP_TICKS = 9'(STARTUP_WAIT_US * 1000 / BACKUP_PERIOD_NS);
  localparam logic [8:0] SWITCH_TICKS = 9'(SWITCH_MUTE_US * 1000 / BACKUP_PERIOD_NS);
  localparam logic [8:0] RELOCK_TICKS = 9'(RELOCK_WAIT_US * 1000 / BACKUP_PERIOD_NS);
  localparam logic [8:0] LOCK_FILTER_TICKS = 9'(LOCK_FILTER_US * 1000 / BACKUP_PERIOD_NS);
  // ----------------------------------------
  // frequency window
  // ----------------------------------------
  localparam logic [2:0] WINDOW_PERIODS = 3'h6;
  localparam logic [7:0] MAX_24 = 8'h00a5;
  localparam logic [7:0] MIN_24 = 8'h007d;
  localparam logic [7:0] MAX_12 = 8'h0054;
  localparam logic [7:0] MIN_12 = 8'h003d;
  // ----------------------------------------
  // clock manager states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_DISABLED, ST_FILTER, ST_EXTERNAL, ST_LOCK_BACKUP, ST_BACKUP, ST_SWITCH
  } mgr_state_t;
endpackage : clock_monitor_pkg

// ---- hdl/freq_window.sv ----
// synthesized clock frequency window counter
`timescale 1ns/1ps
`default_nettype none
module freq_window (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // reference and measured events
  input wire logic backup_tick,
  input wire logic synth_tick,
  input wire logic factor_24_req,
  // result
  output logic window_done,
  output logic window_bad,
  output logic factor_24
);
  typedef struct packed {
    logic [2:0] periods;
    logic [7:0] count;
    logic done;
    logic bad;
    logic f24;
  } win_t;
  win_t cur, next_cur;

  function automatic logic out_of_range(input logic [7:0] n, input logic f24);
    if (f24) begin
      out_of_range = (n > clock_monitor_pkg::MAX_24) || (n < clock_monitor_pkg::MIN_24);
    end else begin
      out_of_range = (n > clock_monitor_pkg::MAX_12) || (n < clock_monitor_pkg::MIN_12);
    end
  endfunction : out_of_range

  always_comb begin
    next_cur = cur;
    next_cur.done = 1'b0;
    if (synth_tick && cur.count != 8'hff) begin
      next_cur.count = cur.count + 8'h01;
    end
    if (backup_tick) begin
      if (cur.periods == clock_monitor_pkg::WINDOW_PERIODS - 3'h1) begin
        next_cur.periods = 3'h0;
        next_cur.count = {7'h00, synth_tick};
        next_cur.done = 1'b1;
        next_cur.bad = out_of_range(cur.count, cur.f24);
        next_cur.f24 = factor_24_req;
      end else begin
        next_cur.periods = cur.periods + 3'h1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cur <= '{periods: 3'h0, count: 8'h00, done: 1'b0, bad: 1'b0, f24: 1'b1};
    end else begin
      cur <= next_cur;
    end
  end

  assign window_done = cur.done;
  assign window_bad = cur.bad;
  assign factor_24 = cur.f24;
endmodule : freq_window
`default_nettype wire

// ---- bench/synth_ref_model.sv ----
// reference clock and multiplier model
`timescale 1ns/1ps
`default_nettype none
module synth_ref_model (
  // clock and control
  input wire logic clk_sys,
  input wire logic ref_select_backup,
  input wire logic [4:0] ext_ticks,
  input wire logic lock_drop,
  // reference and multiplier
  output logic backup_tick,
  output logic synth_tick,
  output logic synth_lock_raw
);
  logic [4:0] phase = 5'h00;
  logic [4:0] ticks;
  // 1 MHz reference is one tick in twenty system cycles
  always @(posedge clk_sys) phase <= (phase == 5'h13) ? 5'h00 : phase + 5'h01;
  // backup source always gives a good x12 count
  assign ticks = ref_select_backup ? 5'h0c : ext_ticks;
  assign backup_tick = phase == 5'h00;
  assign synth_tick = phase < ticks;
  assign synth_lock_raw = !lock_drop;
endmodule : synth_ref_model
`default_nettype wire

// ---- bench/clock_monitor_and_reset_gen_chk.sv ----
// port checker for the clock monitor and reset generator
`timescale 1ns/1ps
`default_nettype none
module clock_monitor_chk #(
  parameter logic [8:0] LOCK_FILTER = clock_monitor_pkg::LOCK_FILTER_TICKS
) (
  // clock and sources
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ext_reset_n,
  input wire logic power_on_reset_n,
  input wire logic backup_tick,
  // requests
  input wire logic reg_wr,
  input wire logic [9:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic spi_start,
  // outputs
  input wire logic spi_abort,
  input wire logic ref_select_backup,
  input wire logic spread_enable,
  input wire logic backup_ref_in_use,
  input wire logic clk_absent,
  input wire logic core_irq,
  input wire logic host_interrupt_n,
  input wire logic drivers_disable,
  input wire logic clk_mon_reset,
  input wire logic cipher_reset,
  input wire logic spi_reset,
  input wire logic main_reset
);
  logic wr_ok;
  assign wr_ok = reg_wr && !main_reset;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  chk_irq_follow: assert property (core_irq == clk_absent && host_interrupt_n != clk_absent)
    else $error("interrupt outputs differ from clock absent");
  chk_drv_cause: assert property (drivers_disable |-> clk_absent)
    else $error("drivers disabled without clock absent");
  chk_in_use_ref: assert property (backup_ref_in_use |-> ref_select_backup)
    else $error("backup in use while external reference fed");
  chk_spread_wr: assert property (wr_ok && reg_addr == clock_monitor_pkg::ADDR_SYNTH_CONFIG
    |=> spread_enable == !$past(reg_wdata[clock_monitor_pkg::BIT_SPREAD_OFF]))
    else $error("spread enable not taken from config write");
  chk_absent_spi: assert property (clk_absent && $past(clk_absent) |-> spi_reset)
    else $error("serial reset low while clock absent");
  chk_pin_reset: assert property (!ext_reset_n |=>
    main_reset && spi_reset && clk_mon_reset)
    else $error("pin reset not passed on");
  chk_por_reset: assert property (!power_on_reset_n |=>
    cipher_reset && clk_mon_reset && main_reset)
    else $error("power-on reset not passed on");
  chk_cipher_por: assert property (power_on_reset_n && !$past(reset)
    && $past(power_on_reset_n) |-> !cipher_reset)
    else $error("cipher reset without power-on reset");
  chk_abort_absent: assert property (spi_start && clk_absent |=> spi_abort)
    else $error("transfer not aborted while clock absent");
  chk_switch_back: assert property (wr_ok && reg_addr == clock_monitor_pkg::ADDR_BACKUP_STATUS
    && reg_wdata[clock_monitor_pkg::BIT_SWITCH_BACK] && backup_ref_in_use && !clk_absent
    |=> clk_absent && !backup_ref_in_use && !ref_select_backup)
    else $error("switch-back request not honoured");
  chk_mon_release: assert property ($fell(clk_mon_reset) |-> $past(backup_tick))
    else $error("monitor reset released off the reference tick");
  cov_backup: cover property ($rose(backup_ref_in_use));
  cov_switch: cover property ($fell(backup_ref_in_use) && clk_absent);
  cov_abort: cover property (spi_abort);
endmodule : clock_monitor_chk
bind clock_monitor_and_reset_gen clock_monitor_chk #(.LOCK_FILTER(LOCK_FILTER)) clock_monitor_chk_i (
  .clk_sys, .reset, .ext_reset_n, .power_on_reset_n, .backup_tick, .reg_wr, .reg_addr,
  .reg_wdata, .spi_start, .spi_abort, .ref_select_backup, .spread_enable, .backup_ref_in_use,
  .clk_absent, .core_irq, .host_interrupt_n, .drivers_disable, .clk_mon_reset, .cipher_reset,
  .spi_reset, .main_reset
);
`default_nettype wire

// ---- bench/clock_monitor_and_reset_gen_bench.sv ----
// bench for the clock monitor and reset generator
`timescale 1ns/1ps
`default_nettype none
`define CHECK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module clock_monitor_and_reset_gen_bench;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic ext_reset_n = 1'b1, power_on_reset_n = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic spi_cs_n = 1'b1, spi_start = 1'b0, rd_d = 1'b0, lock_drop = 1'b0;
  logic [9:0] reg_addr = 10'h000;
  logic [15:0] reg_wdata = 16'h0000;
  logic [4:0] ext_ticks = 5'h0c;
  logic backup_tick, synth_tick, synth_lock_raw, spi_abort, ref_select_backup, synth_factor_24;
  logic spread_enable, sys_clk_enable, backup_ref_in_use, clk_absent, core_irq, host_interrupt_n;
  logic drivers_disable, clk_mon_reset, cipher_reset, spi_reset, main_reset;
  logic [15:0] reg_rdata, r, exp_v;
  logic [15:0] exp_q[$];
  int num_errors = 0, n_tests = 0, cyc = 0, t = 0;
  always #25 clk_sys = ~clk_sys;
  clock_monitor_and_reset_gen #(.LOCK_FILTER(9'h002)) clock_monitor_and_reset_gen_i (
    .clk_sys, .reset, .ext_reset_n, .power_on_reset_n, .backup_tick, .synth_tick,
    .synth_lock_raw, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .spi_cs_n, .spi_start,
    .spi_abort, .ref_select_backup, .synth_factor_24, .spread_enable, .sys_clk_enable,
    .backup_ref_in_use, .clk_absent, .core_irq, .host_interrupt_n, .drivers_disable,
    .clk_mon_reset, .cipher_reset, .spi_reset, .main_reset
  );
  synth_ref_model synth_ref_model_i (
    .clk_sys, .ref_select_backup, .ext_ticks, .lock_drop, .backup_tick, .synth_tick,
    .synth_lock_raw
  );
  // ----
  // read data watcher and hang limit
  // ----
  always @(posedge clk_sys) begin
    rd_d <= reg_rd;
    if (rd_d) begin
      exp_v = exp_q.pop_front();
      `CHECK(reg_rdata, exp_v)
    end
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up
  // ----
  // register and wait tasks
  // ----
  task automatic wr(input logic [9:0] a, input logic [15:0] d);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [15:0] e);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
  endtask : rd
  task automatic wait_sig(input logic sel, input logic v, input int lim);
    t = 0;
    while ((sel ? backup_ref_in_use : clk_absent) !== v && t < lim) begin
      @(posedge clk_sys);
      t++;
    end
  endtask : wait_sig
  task automatic to_backup(input logic [4:0] k, input logic [15:0] st);
    ext_ticks <= k;
    wait_sig(1'b1, 1'b1, 1000);
    `CHECK({ref_select_backup, clk_absent}, 2'b11)
    wait_sig(1'b0, 1'b0, 1000);
    `CHECK(backup_ref_in_use, 1'b1)
    rd(clock_monitor_pkg::ADDR_BACKUP_STATUS, st);
  endtask : to_backup
  task automatic sw_back();
    wr(clock_monitor_pkg::ADDR_BACKUP_STATUS, 16'h0006);
    `CHECK({clk_absent, backup_ref_in_use, ref_select_backup}, 3'b100)
  endtask : sw_back
  // ----
  // main sequence
  // ----
  initial begin
    void'($urandom(39834));
    repeat (10) @(posedge clk_sys);
    reset <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rd(clock_monitor_pkg::ADDR_SYNTH_CONFIG, clock_monitor_pkg::SYNTH_CONFIG_RESET);
    for (int i = 0; i < 2; i++) begin
      r = i ? (r ^ 16'h0002) : (16'($urandom) & 16'h0002);
      wr(clock_monitor_pkg::ADDR_SYNTH_CONFIG, r);
      `CHECK(spread_enable, ~r[1])
      rd(clock_monitor_pkg::ADDR_SYNTH_CONFIG, r);
    end
    wr(10'h1c9, 16'($urandom));
    rd(10'h1c9, 16'h0000);
    `CHECK({clk_absent, backup_ref_in_use, ref_select_backup}, 3'b000)
    repeat (2600) @(posedge clk_sys);
    `CHECK({sys_clk_enable, clk_absent, backup_ref_in_use, synth_factor_24}, 4'b1000)
    ext_ticks <= 5'h0e;
    repeat (1000) @(posedge clk_sys);
    `CHECK(backup_ref_in_use, 1'b0)
    to_backup(5'h0a, 16'h0001);
    ext_ticks <= 5'h0c;
    repeat (6000) @(posedge clk_sys);
    `CHECK(backup_ref_in_use, 1'b1)
    sw_back();
    @(posedge clk_sys);
    `CHECK({drivers_disable, core_irq, host_interrupt_n, spi_reset}, 4'b1101)
    spi_cs_n <= 1'b0;
    spi_start <= 1'b1;
    @(posedge clk_sys);
    spi_start <= 1'b0;
    @(posedge clk_sys);
    `CHECK(spi_abort, 1'b1)
    spi_cs_n <= 1'b1;
    wait_sig(1'b0, 1'b0, 8000);
    `CHECK(t > 1970 && t < 8000, 1'b1)
    `CHECK({backup_ref_in_use, ref_select_backup}, 2'b00)
    rd(clock_monitor_pkg::ADDR_SPI_ERROR, 16'h0001);
    rd(clock_monitor_pkg::ADDR_SPI_ERROR, 16'h0000);
    to_backup(5'h0a, 16'h0003);
    sw_back();
    wait_sig(1'b1, 1'b1, 8000);
    `CHECK(t > 4900 && t < 8000, 1'b1)
    wr(clock_monitor_pkg::ADDR_GLOBAL_RESET_1, clock_monitor_pkg::GLOBAL_CODE_1);
    wr(clock_monitor_pkg::ADDR_GLOBAL_RESET_2, clock_monitor_pkg::GLOBAL_CODE_2);
    @(posedge clk_sys);
    `CHECK({main_reset, spi_reset, clk_mon_reset, cipher_reset}, 4'b1100)
    t = 0;
    while (main_reset === 1'b1 && t < 20) begin
      @(posedge clk_sys);
      t++;
    end
    `CHECK(t > 4 && t < 9, 1'b1)
    rd(clock_monitor_pkg::ADDR_SYNTH_CONFIG, clock_monitor_pkg::SYNTH_CONFIG_RESET);
    ext_reset_n <= 1'b0;
    ext_ticks <= 5'h14;
    repeat (3) @(posedge clk_sys);
    `CHECK({main_reset, spi_reset, clk_mon_reset, cipher_reset}, 4'b1110)
    ext_reset_n <= 1'b1;
    repeat (25) @(posedge clk_sys);
    `CHECK(clk_mon_reset, 1'b0)
    wait_sig(1'b1, 1'b1, 4000);
    `CHECK({backup_ref_in_use, synth_factor_24}, 2'b11)
    power_on_reset_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    `CHECK(cipher_reset, 1'b1)
    power_on_reset_n <= 1'b1;
    repeat (25) @(posedge clk_sys);
    `CHECK({cipher_reset, main_reset}, 2'b00)
    lock_drop <= 1'b1;
    repeat (3) @(posedge clk_sys);
    `CHECK(sys_clk_enable, 1'b0)
    wrap_up();
  end
endmodule : clock_monitor_and_reset_gen_bench
`default_nettype wire
